// ===== hw/i2c_master_status_address_rx.v
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_master_regs.vh"

module i2c_master_status_address_rx #(
	parameter integer CLK_PERIOD_NS = `CLK_PERIOD_NS
) (
	input wire sys_clk,
	input wire rst,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	output reg irq,
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe_n,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n
);

// ----------------------------------------------------------------
// Timing and states
// ----------------------------------------------------------------
// The serial clock period is a least time, so each quarter rounds up.
localparam integer QDIV = `QUARTERS_PER_BIT * CLK_PERIOD_NS;
localparam integer STD_Q = (`STD_PERIOD_NS + QDIV - 1) / QDIV;
localparam integer FAST_Q = (`FAST_PERIOD_NS + QDIV - 1) / QDIV;
localparam [9:0] STD_RELOAD = STD_Q[9:0] - 10'h001;
localparam [9:0] FAST_RELOAD = FAST_Q[9:0] - 10'h001;

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_START = 3'h1;
localparam [2:0] S_SHIFT = 3'h2;
localparam [2:0] S_STOP = 3'h3;
localparam [2:0] S_HOLD = 3'h4;
localparam [2:0] S_RXWAIT = 3'h5;

localparam [1:0] K_ADDR = 2'h0;
localparam [1:0] K_TX = 2'h1;
localparam [1:0] K_RX = 2'h2;

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg stop_after_transmit;
reg stop_after_receive;
reg transmit_irq_enable;
reg receive_irq_enable;
reg speed_fast;
reg bus_error_flag;
reg transmitter_empty_flag;
reg receiver_full_flag;
reg [7:0] i2c_slave_address;
reg [7:0] i2c_transmit_data;
reg [7:0] i2c_receive_data;
reg [2:0] irq_status;
reg [2:0] irq_mask;

reg [2:0] state;
reg [1:0] quarter;
reg [9:0] div_cnt;
reg [3:0] bit_idx;
reg [1:0] kind;
reg [7:0] shift;
reg [7:0] sent_addr;
reg nack_sent;
reg ev_tx_copy;
reg ev_rx_load;
reg ev_nack;
reg scl_m;
reg scl_s;
reg sda_m;
reg sda_s;
reg [7:0] read_mux;

wire wr_status = wr && (addr == `REG_STATUS);
wire wr_slave = wr && (addr == `REG_SLAVE_ADDR);
wire wr_tx = wr && (addr == `REG_TX_DATA);
wire wr_mask = wr && (addr == `REG_IRQ_MASK);
wire rd_rx = rd && (addr == `REG_RX_DATA);
wire rd_irq = rd && (addr == `REG_IRQ_STATUS);

wire [9:0] q_reload = speed_fast ? FAST_RELOAD : STD_RELOAD;
// Holds the count while a released clock line is still low (slave stretch).
wire stretch = scl_oe_n && !scl_s;
wire tick = (div_cnt == 10'h000) && !stretch;
wire [7:0] shift_in = {shift[6:0], sda_s};

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		scl_m <= 1'b1;
		scl_s <= 1'b1;
		sda_m <= 1'b1;
		sda_s <= 1'b1;
	end else begin
		scl_m <= scl_in;
		scl_s <= scl_m;
		sda_m <= sda_in;
		sda_s <= sda_m;
	end
end

// ----------------------------------------------------------------
// Software-written control
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		stop_after_transmit <= 1'b0;
		stop_after_receive <= 1'b0;
		transmit_irq_enable <= 1'b0;
		receive_irq_enable <= 1'b0;
		speed_fast <= 1'b0;
		i2c_slave_address <= `BYTE_RST;
		i2c_transmit_data <= `BYTE_RST;
		irq_mask <= `IRQ_MASK_RST;
	end else begin
		if (wr_status) begin
			stop_after_transmit <= wdata[`STAT_STOP_TX];
			stop_after_receive <= wdata[`STAT_STOP_RX];
			transmit_irq_enable <= wdata[`STAT_TX_IRQ_EN];
			receive_irq_enable <= wdata[`STAT_RX_IRQ_EN];
			speed_fast <= wdata[`STAT_FAST];
		end
		if (wr_slave) begin
			i2c_slave_address <= wdata;
		end
		if (wr_tx) begin
			i2c_transmit_data <= wdata;
		end
		if (wr_mask) begin
			irq_mask <= wdata[2:0];
		end
	end
end

// ----------------------------------------------------------------
// Handshake flags
// ----------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		transmitter_empty_flag <= `TX_EMPTY_RST;
		receiver_full_flag <= 1'b0;
		bus_error_flag <= 1'b0;
		irq_status <= 3'h0;
	end else begin
		// Set on copy to shifter; a refused address drops the pending byte.
		if (ev_tx_copy || ev_nack) begin
			transmitter_empty_flag <= 1'b1;
		end else if (wr_tx) begin
			transmitter_empty_flag <= 1'b0;
		end
		if (ev_rx_load) begin
			receiver_full_flag <= 1'b1;
		end else if (rd_rx) begin
			receiver_full_flag <= 1'b0;
		end
		if (ev_nack) begin
			bus_error_flag <= 1'b1;
		end else if (wr_status && wdata[`STAT_BUS_ERR]) begin
			bus_error_flag <= 1'b0;
		end
		irq_status <= (irq_status & ~{3{rd_irq}}) | {ev_nack, ev_rx_load, ev_tx_copy};
	end
end

// ----------------------------------------------------------------
// Register read port and interrupt output
// ----------------------------------------------------------------
always @* begin
	if (addr == `REG_STATUS) begin
		read_mux = {receiver_full_flag, receive_irq_enable, bus_error_flag, speed_fast,
			transmitter_empty_flag, transmit_irq_enable, stop_after_receive,
			stop_after_transmit};
	end else if (addr == `REG_SLAVE_ADDR) begin
		read_mux = i2c_slave_address;
	end else if (addr == `REG_RX_DATA) begin
		read_mux = i2c_receive_data;
	end else if (addr == `REG_TX_DATA) begin
		read_mux = i2c_transmit_data;
	end else if (addr == `REG_IRQ_STATUS) begin
		read_mux = {5'h00, irq_status};
	end else if (addr == `REG_IRQ_MASK) begin
		read_mux = {5'h00, irq_mask};
	end else begin
		read_mux = 8'h00;
	end
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		rdata <= 8'h00;
		irq <= 1'b0;
	end else begin
		rdata <= rd ? read_mux : 8'h00;
		irq <= |(irq_status & irq_mask & {1'b1, receive_irq_enable, transmit_irq_enable});
	end
end

// ----------------------------------------------------------------
// Serial sequencer
// ----------------------------------------------------------------
// The lines are only driven low or released; nothing compares a
// driven level against the line, so there is no arbitration.
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		state <= S_IDLE;
		quarter <= 2'h0;
		div_cnt <= 10'h000;
		bit_idx <= 4'h0;
		kind <= K_ADDR;
		shift <= `BYTE_RST;
		sent_addr <= `BYTE_RST;
		nack_sent <= 1'b0;
		ev_tx_copy <= 1'b0;
		ev_rx_load <= 1'b0;
		ev_nack <= 1'b0;
		i2c_receive_data <= `BYTE_RST;
		scl_out <= 1'b0;
		sda_out <= 1'b0;
		scl_oe_n <= 1'b1;
		sda_oe_n <= 1'b1;
	end else begin
		ev_tx_copy <= 1'b0;
		ev_rx_load <= 1'b0;
		ev_nack <= 1'b0;
		if (div_cnt != 10'h000 && !stretch) begin
			div_cnt <= div_cnt - 10'h001;
		end
		if (tick && (state == S_START || state == S_SHIFT || state == S_STOP)) begin
			quarter <= quarter + 2'h1;
			div_cnt <= q_reload;
		end else if (state == S_IDLE || state == S_HOLD || state == S_RXWAIT) begin
			quarter <= 2'h0;
			div_cnt <= q_reload;
		end
		case (state)
		S_IDLE: begin
			if (!transmitter_empty_flag) begin
				state <= S_START;
			end
		end
		S_HOLD: begin
			if (!transmitter_empty_flag) begin
				if (i2c_slave_address != sent_addr) begin
					state <= S_START;
				end else begin
					shift <= i2c_transmit_data;
					kind <= K_TX;
					bit_idx <= 4'h0;
					ev_tx_copy <= 1'b1;
					state <= S_SHIFT;
				end
			end
		end
		S_RXWAIT: begin
			if (!receiver_full_flag) begin
				state <= S_SHIFT;
			end
		end
		S_START: begin
			if (tick) begin
				case (quarter)
				2'h0: sda_oe_n <= 1'b1;
				2'h1: scl_oe_n <= 1'b1;
				2'h2: sda_oe_n <= 1'b0;
				default: begin
					scl_oe_n <= 1'b0;
					shift <= i2c_slave_address;
					sent_addr <= i2c_slave_address;
					kind <= K_ADDR;
					bit_idx <= 4'h0;
					state <= S_SHIFT;
				end
				endcase
			end
		end
		S_SHIFT: begin
			if (tick) begin
				case (quarter)
				2'h0: sda_oe_n <= (bit_idx != `BYTE_BITS) ? (kind == K_RX || shift[7]) :
					(kind != K_RX || nack_sent);
				2'h1: scl_oe_n <= 1'b0;
				2'h2: scl_oe_n <= 1'b1;
				default: begin
					scl_oe_n <= 1'b0;
					if (bit_idx != `BYTE_BITS) begin
						shift <= shift_in;
						bit_idx <= bit_idx + 4'h1;
						if (kind == K_RX && bit_idx == `BYTE_BITS - 4'h1) begin
							i2c_receive_data <= shift_in;
							ev_rx_load <= 1'b1;
							nack_sent <= stop_after_receive;
							if (!stop_after_receive) begin
								state <= S_RXWAIT;
							end
						end
					end else begin
						bit_idx <= 4'h0;
						case (kind)
						K_ADDR: begin
							if (sda_s) begin
								ev_nack <= 1'b1;
								state <= S_STOP;
							end else begin
								shift <= i2c_transmit_data;
								kind <= sent_addr[`ADDR_DIR_BIT] ? K_RX : K_TX;
								ev_tx_copy <= 1'b1;
							end
						end
						K_TX: begin
							ev_nack <= sda_s;
							state <= (sda_s || stop_after_transmit) ? S_STOP : S_HOLD;
						end
						default: begin
							if (nack_sent) begin
								state <= S_STOP;
							end
						end
						endcase
					end
				end
				endcase
			end
		end
		S_STOP: begin
			if (tick) begin
				case (quarter)
				2'h0: sda_oe_n <= 1'b0;
				2'h1: scl_oe_n <= 1'b1;
				2'h2: sda_oe_n <= 1'b1;
				default: state <= S_IDLE;
				endcase
			end
		end
		default: state <= S_IDLE;
		endcase
	end
end

endmodule // i2c_master_status_address_rx
`default_nettype wire

// ===== hw/i2c_master_regs.vh
// Operation
// - Stop-after-transmit 0: no stop after a sent byte; 1: stop follows. Resets 0.
// - Stop-after-receive at bit 1: 1 issues stop after a received byte.
// - Transmitter-empty resets 1; set when transmit byte enters shift register.
// - Writing the transmit data register clears transmitter-empty.
// - Transmitter-empty interrupts only while transmit interrupt enable (bit 2) is 1.
// - Receiver-full (bit 7) sets when a received byte is loaded.
// - Reading the receive data register clears receiver-full.
// - Receiver-full interrupts only while receive interrupt enable (bit 6) is 1.
// - Bus error (bit 5) sets when the addressed slave does not acknowledge.
// - Writing 1 clears bus error; writing 0 leaves it unchanged.
// - Slave address in bits 7..1, direction in bit 0 (1 read); reset zero.
// - Receive data register is read-only, resets 0, holds last received byte.
// - Writing the transmit data register starts a serial transfer.
// - A transaction begins with start condition, then the address register byte.
// - Single master only; no multi-master arbitration.
`ifndef I2C_MASTER_REGS_VH
`define I2C_MASTER_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_STATUS 3'h0
`define REG_SLAVE_ADDR 3'h1
`define REG_RX_DATA 3'h2
`define REG_TX_DATA 3'h3
`define REG_IRQ_STATUS 3'h4
`define REG_IRQ_MASK 3'h5

// ----------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------
`define STAT_STOP_TX 0
`define STAT_STOP_RX 1
`define STAT_TX_IRQ_EN 2
`define STAT_TX_EMPTY 3
`define STAT_FAST 4
`define STAT_BUS_ERR 5
`define STAT_RX_IRQ_EN 6
`define STAT_RX_FULL 7
`define ADDR_DIR_BIT 0

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define IRQ_TX 0
`define IRQ_RX 1
`define IRQ_ERR 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TX_EMPTY_RST 1'b1
`define BYTE_RST 8'h00
`define IRQ_MASK_RST 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define STD_PERIOD_NS 10000
`define FAST_PERIOD_NS 2500
`define QUARTERS_PER_BIT 4
`define BYTE_BITS 4'h8

`endif

// ===== dv/i2c_master_props.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_master_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic irq,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	input wire logic scl_out,
	input wire logic sda_out
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (rd && addr[2:1] == 2'b11 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_addr_back: assert property (wr && addr == 3'h1 ##1 rd && addr == 3'h1
		|=> rdata == $past(wdata, 2)) else $error("address readback wrong");
	a_ctrl_back: assert property (wr && addr == 3'h0 ##1 rd && addr == 3'h0
		|=> (rdata & 8'h57) == ($past(wdata, 2) & 8'h57)) else $error("control readback wrong");
	a_txe_clear: assert property (wr && addr == 3'h3 ##1 rd && addr == 3'h0 |=> !rdata[3])
		else $error("empty flag not cleared by transmit write");
	a_rxf_clear: assert property (rd && addr == 3'h2 ##1 rd && addr == 3'h0 |=> !rdata[7])
		else $error("full flag not cleared by data read");
	a_err_clear: assert property (wr && addr == 3'h0 && wdata[5] ##1 rd && addr == 3'h0
		|=> !rdata[5]) else $error("bus error not cleared by writing one");
	a_lines_idle: assert property ($fell(rst) |-> scl_oe_n && sda_oe_n && !irq)
		else $error("lines not released after reset");
	a_pins_low: assert property (!scl_out && !sda_out)
		else $error("line outputs not held low");
	cover property (wr && addr == 3'h3);
	cover property ($fell(sda_oe_n) && scl_oe_n);
	cover property ($rose(irq));
endmodule // i2c_master_props
bind i2c_master_status_address_rx i2c_master_props i2c_master_props_inst (.sys_clk(sys_clk),
	.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
	.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .scl_out(scl_out), .sda_out(sda_out));
`default_nettype wire

// ===== dv/i2c_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model #(
	parameter [6:0] DEV = 7'h2A
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic [7:0] tx_byte,
	output logic sda_pull,
	output logic [7:0] got
);
	logic on = 0, adr = 0, rmode = 0, rgo = 0;
	logic [7:0] sh = 0;
	int bitc = 0;
	initial sda_pull = 0;
	initial got = 0;
	always @(negedge sda)
		if (scl === 1'b1) begin
			on = 1;
			adr = 1;
			rmode = 0;
			bitc = 0;
			sda_pull = 0;
		end
	always @(posedge sda)
		if (scl === 1'b1) begin
			on = 0;
			sda_pull = 0;
		end
	always @(posedge scl)
		if (on) begin
			if (bitc < 8) begin
				sh = {sh[6:0], sda};
				bitc++;
			end else begin
				rgo = adr ? rmode && sda_pull : (sda == 1'b0);
				adr = 0;
				bitc = 0;
			end
		end
	always @(negedge scl)
		if (on) begin
			if (bitc == 8) begin
				if (adr)
					rmode = sh[0];
				if (!adr && !rmode)
					got = sh;
				sda_pull = !nack && (adr ? sh[7:1] == DEV : !rmode);
			end else
				sda_pull = rmode && rgo && !adr && !tx_byte[7 - bitc];
		end
endmodule // i2c_slave_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2c_master_regs.vh"
module tb_top;
	localparam [6:0] dev = 7'h2A;
	localparam int bit_cyc = 4 * ((`FAST_PERIOD_NS + 15) / 16);
	localparam int std_cyc = 4 * ((`STD_PERIOD_NS + 15) / 16);
	logic sys_clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, nack = 0;
	logic [2:0] addr = 0;
	logic [7:0] wdata = 0, e, m, b = 0, got, rdata;
	logic [31:0] seed = 32'hB272;
	logic irq, scl_out, scl_oe_n, sda_out, sda_oe_n, pull;
	wire scl_w = scl_oe_n;
	wire sda_w = sda_oe_n & ~pull;
	int bad_count = 0, checks_done = 0, cyc = 0, stops = 0, starts = 0, per = 0, t0 = 0, n;
	logic [7:0] exp_q[$], msk_q[$];
	always #2 sys_clk = ~sys_clk;
	i2c_master_status_address_rx i2c_master_status_address_rx_inst (.sys_clk(sys_clk),
		.rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n));
	i2c_slave_model #(.DEV(dev)) i2c_slave_model_inst (.scl(scl_w), .sda(sda_w), .nack(nack),
		.tx_byte(b), .sda_pull(pull), .got(got));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string nm);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1;
		rd <= 0;
		@(posedge sys_clk);
	endtask
	task automatic rd_reg(input logic [2:0] a, input logic [7:0] x, input logic [7:0] k);
		addr <= a;
		rd <= 1;
		wr <= 0;
		exp_q.push_back(x);
		msk_q.push_back(k);
		@(posedge sys_clk);
	endtask
	// Waits for the interrupt, or for the stop counter to leave s.
	task automatic wait_event(input bit use_irq, input int s);
		wr <= 0;
		rd <= 0;
		for (n = 0; n < 40000 && (use_irq ? irq !== 1'b1 : stops == s); n++)
			@(posedge sys_clk);
		// A wait that runs out counts as a mismatch.
		if (n >= 40000)
			bad_count++;
		repeat (4) @(posedge sys_clk);
	endtask
	// ----
	// Monitors
	// ----
	always @(posedge sys_clk) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			check(rdata & m, e & m, "rdata");
		end
		rd_d <= rd;
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			final_report();
		end
	end
	always @(posedge sda_w)
		if (scl_w === 1'b1 && cyc > 12)
			stops++;
	always @(negedge sda_w)
		if (scl_w === 1'b1 && cyc > 12)
			starts++;
	always @(posedge scl_w) begin
		per = cyc - t0;
		t0 = cyc;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		rd_reg(`REG_STATUS, 8'h08, 8'hFF);
		rd_reg(`REG_SLAVE_ADDR, 8'h00, 8'hFF);
		rd_reg(`REG_IRQ_MASK, 8'h07, 8'hFF);
		wr_reg(`REG_RX_DATA, 8'hFF);
		wr_reg(3'h7, 8'hFF);
		rd_reg(`REG_RX_DATA, 8'h00, 8'hFF);
		rd_reg(3'h7, 8'h00, 8'hFF);
		repeat (4) begin
			seed = lfsr(seed);
			wr_reg(`REG_STATUS, seed[7:0]);
			rd_reg(`REG_STATUS, seed[7:0], 8'h57);
			wr_reg(`REG_SLAVE_ADDR, seed[15:8]);
			rd_reg(`REG_SLAVE_ADDR, seed[15:8], 8'hFF);
		end
		seed = lfsr(seed);
		wr_reg(`REG_SLAVE_ADDR, {dev, 1'b0});
		wr_reg(`REG_STATUS, 8'h35);
		wr_reg(`REG_TX_DATA, seed[7:0]);
		rd_reg(`REG_STATUS, 8'h00, 8'h08);
		wait_event(1, 0);
		check((per >= bit_cyc - 3 && per <= bit_cyc + 3) ? 8'h1 : 8'h0, 8'h1, "bit_time");
		rd_reg(`REG_STATUS, 8'h08, 8'h08);
		rd_reg(`REG_IRQ_STATUS, 8'h01, 8'h07);
		rd_reg(`REG_IRQ_STATUS, 8'h00, 8'h07);
		wait_event(0, 0);
		check({7'h0, irq}, 8'h0, "irq");
		check(got, seed[7:0], "slave_byte");
		check(starts[7:0], 8'h1, "starts");
		check(stops[7:0], 8'h1, "stops");
		nack <= 1;
		wr_reg(`REG_STATUS, 8'h05);
		wr_reg(`REG_TX_DATA, 8'hA5);
		wait_event(1, 0);
		check((per >= std_cyc - 3 && per <= std_cyc + 3) ? 8'h1 : 8'h0, 8'h1, "bit_time_std");
		wait_event(0, 1);
		rd_reg(`REG_STATUS, 8'h20, 8'h20);
		wr_reg(`REG_STATUS, 8'h15);
		rd_reg(`REG_STATUS, 8'h20, 8'h20);
		wr_reg(`REG_STATUS, 8'h35);
		rd_reg(`REG_STATUS, 8'h00, 8'h20);
		rd_reg(`REG_IRQ_STATUS, 8'h04, 8'h07);
		nack <= 0;
		seed = lfsr(seed);
		b = seed[7:0];
		wr_reg(`REG_SLAVE_ADDR, {dev, 1'b1});
		wr_reg(`REG_STATUS, 8'h52);
		wr_reg(`REG_TX_DATA, 8'h00);
		wait_event(1, 0);
		rd_reg(`REG_STATUS, 8'h80, 8'h80);
		rd_reg(`REG_RX_DATA, b, 8'hFF);
		rd_reg(`REG_STATUS, 8'h00, 8'h80);
		rd_reg(`REG_IRQ_STATUS, 8'h03, 8'h07);
		wait_event(0, 2);
		check(stops[7:0], 8'h3, "stops");
		final_report();
	end
endmodule // tb_top
`default_nettype wire
